// [design/bc_bus_ctl.sv]
`timescale 1ns/10ps
`include "bc_cfg.svh"
// ****************************************
// processor bus control
// ****************************************
// Overview of operation
// R1: reset pin rising edge starts restart
// R2: reset condition drives upper address high
// R3: fetch pc high from fffe, low ffff
// R4: restart sets mask, software clears it
// R5: reset pin held low eight periods
// R6: first vector address on next phase one
// R7: valid-address strobe marks valid addresses only
// R8: sixteen-bit address bus can float
// R9: float control floats address, read/write
// R10: dma raises float at phase one
// R11: float stretch kept under five microseconds
// R12: eight-bit bidirectional data bus
// R13: data drivers follow data drive enable
// R14: read cycles never drive data bus
// R15: dma master holds data enable low
// R16: read/write high on read, rests high
// R17: read/write floats when floated or halted
// R18: halt low stops at instruction end
// R19: halt pin stable late in phase one
// R20: one phase-one high steps one instruction
// R21: bus available in halt or wait
// R22: wait ends on nmi or unmasked irq
// R23: interrupts sampled phase two, start phase one
module bc_bus_ctl (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst_n,
  // device pins
  input  wire bc_pkg::bc_pins_t      pins,
  input  wire logic [`BC_DATA_W-1:0] data_in,
  output bc_pkg::bc_bus_t            bus,
  // core request side
  input  wire bc_pkg::bc_req_t       core_req,
  input  wire logic                  mask_clear,
  // core answer side
  output logic                       cycle_ack,
  output logic [`BC_DATA_W-1:0]      rd_data,
  output logic                       rd_valid,
  output logic [`BC_ADDR_W-1:0]      pc_value,
  output logic                       pc_load,
  output logic                       int_start,
  output bc_pkg::bc_int_t            int_kind,
  output logic                       int_mask
);
  import bc_pkg::*;

  // ****************************************
  // declarations
  // ****************************************
  bc_pins_t              pins_s;      // synchronised pins
  logic [`BC_DATA_W-1:0] data_s;      // synchronised data bus
  logic                  p1_start;    // phase one begins
  logic                  p2_start;    // phase two begins
  logic                  res_prev_r;  // reset pin, last cycle
  logic                  res_rise;
  logic                  nmi_smp_r;   // nmi level at last sample
  logic                  nmi_pend_r;  // nmi edge waiting
  logic                  irq_req_r;   // irq level at last sample
  logic                  int_mask_r;
  bc_state_t             st_r;
  bc_state_t             st_nxt;
  bc_req_t               cyc_r;       // cycle now on the bus
  bc_req_t               cyc_nxt;
  logic                  take_req;
  logic                  nmi_take;
  logic                  irq_take;
  logic                  int_ok;
  logic [`BC_DATA_W-1:0] vec_hi_r;    // first vector byte
  bc_bus_t               bus_nxt;
  bc_bus_t               bus_r;
  logic                  ack_r;
  logic [`BC_DATA_W-1:0] rd_data_r;
  logic                  rd_valid_r;
  logic [`BC_ADDR_W-1:0] pc_value_r;
  logic                  pc_load_r;
  logic                  int_start_r;
  bc_int_t               int_kind_r;

  // vector read cycle at a fixed address
  function automatic bc_req_t vec_read(input logic [`BC_ADDR_W-1:0] a);
    bc_req_t c;
    c       = '0;
    c.valid = 1'b1;
    c.rw    = 1'b1;
    c.addr  = a;
    return c;
  endfunction

  // ****************************************
  // pin synchronisers and phase timer
  // ****************************************
  bc_pin_sync #(.W(6), .RST(`BC_PIN_RST)) u_pin_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (pins),
    .dout    (pins_s)
  );

  // data bus is a pin too, synchronised every clock like the control pins
  bc_pin_sync #(.W(`BC_DATA_W), .RST(`BC_DATA_RST)) u_data_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .din     (data_in),
    .dout    (data_s)
  );

  // float control parks the cycle in phase one
  bc_phase_gen u_phase_gen (
    .ref_clk  (ref_clk),
    .rst_n    (rst_n),
    .hold     (pins_s.address_float_control),  // R10
    .p1_start (p1_start),
    .p2_start (p2_start),
    .phi2     ()
  );

  // ****************************************
  // reset edge and interrupt sampling
  // ****************************************
  // resets to low so a pin already high still starts a restart
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      res_prev_r <= 1'b0;
    end else begin
      res_prev_r <= pins_s.res_n;
    end
  end
  assign res_rise = pins_s.res_n & ~res_prev_r;  // R1

  // sample in phase two, act at instruction end; edge set beats clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      nmi_smp_r  <= 1'b1;
      nmi_pend_r <= 1'b0;
      irq_req_r  <= 1'b0;
    end else begin
      if (p2_start) begin
        nmi_smp_r <= pins_s.nmi_n;  // R23
        irq_req_r <= ~pins_s.irq_n;  // R23
      end
      if (p2_start && nmi_smp_r && !pins_s.nmi_n) begin
        nmi_pend_r <= 1'b1;
      end else if (nmi_take) begin
        nmi_pend_r <= 1'b0;
      end
    end
  end

  // mask held set through restart; any set wins over a clear
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      int_mask_r <= 1'b1;
    end else if (st_r inside {ST_RESET, ST_VEC_WAIT, ST_VEC_HI, ST_VEC_LO}
                 || nmi_take || irq_take) begin
      int_mask_r <= 1'b1;  // R4
    end else if (mask_clear) begin
      int_mask_r <= 1'b0;  // R4
    end
  end

  // ****************************************
  // cycle sequencer
  // ****************************************
  // all bus decisions except reset entry and exit happen on a phase-one boundary
  always_comb begin
    st_nxt   = st_r;
    cyc_nxt  = cyc_r;
    take_req = 1'b0;
    nmi_take = 1'b0;
    irq_take = 1'b0;
    int_ok   = nmi_pend_r | (irq_req_r & ~int_mask_r);
    if (!pins_s.res_n) begin
      // reset condition overrides everything
      st_nxt  = ST_RESET;
      cyc_nxt = '0;
    end else begin
      case (st_r)
        ST_RESET: begin
          if (res_rise) begin
            st_nxt = ST_VEC_WAIT;  // R1
          end
        end
        ST_VEC_WAIT: begin
          if (p1_start) begin
            cyc_nxt = vec_read(`BC_VEC_HI_ADDR);  // R6
            st_nxt  = ST_VEC_HI;
          end
        end
        ST_VEC_HI: begin
          if (p1_start) begin
            cyc_nxt = vec_read(`BC_VEC_LO_ADDR);  // R3
            st_nxt  = ST_VEC_LO;
          end
        end
        ST_VEC_LO: begin
          if (p1_start) begin
            cyc_nxt = '0;
            st_nxt  = ST_RUN;
          end
        end
        ST_RUN: begin
          if (p1_start) begin
            if (cyc_r.last && !pins_s.halt_n) begin
              // halt wins, interrupts wait while halted
              st_nxt  = ST_HALT;  // R18
              cyc_nxt = '0;
            end else if (cyc_r.last && int_ok) begin
              nmi_take = nmi_pend_r;  // R23
              irq_take = ~nmi_pend_r;
              cyc_nxt  = '0;
            end else if (cyc_r.last && cyc_r.wai) begin
              st_nxt  = ST_WAIT;  // R21
              cyc_nxt = '0;
            end else begin
              cyc_nxt  = core_req;
              take_req = core_req.valid;  // no ack for an empty slot
            end
          end
        end
        ST_HALT: begin
          // one phase one with halt high lets one instruction run
          if (p1_start && pins_s.halt_n) begin
            st_nxt   = ST_RUN;  // R20
            cyc_nxt  = core_req;
            take_req = core_req.valid;
          end
        end
        ST_WAIT: begin
          if (p1_start && int_ok) begin
            st_nxt   = ST_RUN;  // R22
            nmi_take = nmi_pend_r;
            irq_take = ~nmi_pend_r;
          end
        end
        default: begin
          st_nxt  = ST_RESET;
          cyc_nxt = '0;
        end
      endcase
    end
  end

  // state and cycle registers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      st_r  <= ST_RESET;
      cyc_r <= '0;
    end else begin
      st_r  <= st_nxt;
      cyc_r <= cyc_nxt;
    end
  end

  // ****************************************
  // read capture and core answers
  // ****************************************
  // read data is taken at the end of phase two
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      vec_hi_r   <= '0;
      rd_data_r  <= '0;
      rd_valid_r <= 1'b0;
      pc_value_r <= '0;
      pc_load_r  <= 1'b0;
    end else begin
      rd_valid_r <= 1'b0;
      pc_load_r  <= 1'b0;
      if (p1_start && pins_s.res_n && cyc_r.valid && cyc_r.rw) begin
        case (st_r)
          ST_VEC_HI: vec_hi_r <= data_s;  // R3
          ST_VEC_LO: begin
            pc_value_r <= {vec_hi_r, data_s};  // R3
            pc_load_r  <= 1'b1;
          end
          default: begin
            rd_data_r  <= data_s;  // R12
            rd_valid_r <= 1'b1;
          end
        endcase
      end
    end
  end

  // acceptance and interrupt start pulses
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      ack_r       <= 1'b0;
      int_start_r <= 1'b0;
      int_kind_r  <= INT_NMI;
    end else begin
      ack_r       <= take_req;
      int_start_r <= nmi_take | irq_take;  // R23
      if (nmi_take || irq_take) begin
        int_kind_r <= nmi_take ? INT_NMI : INT_IRQ;
      end
    end
  end

  // ****************************************
  // pin drivers
  // ****************************************
  // float control is applied last; it leaves the data bus alone
  always_comb begin
    bus_nxt.addr                 = cyc_r.addr;
    bus_nxt.addr_oe              = 1'b1;
    bus_nxt.rw                   = cyc_r.valid ? cyc_r.rw : 1'b1;  // R16
    bus_nxt.rw_oe                = 1'b1;
    bus_nxt.data                 = cyc_r.wdata;
    bus_nxt.data_oe              = cyc_r.valid & ~cyc_r.rw  // R14
                                   & pins_s.data_drive_enable;  // R13
    bus_nxt.valid_address_strobe = cyc_r.valid;  // R7
    bus_nxt.bus_avail            = 1'b0;
    case (st_r)
      ST_RESET: begin
        bus_nxt.addr                 = `BC_RST_ADDR;  // R2
        bus_nxt.data_oe              = 1'b0;
        bus_nxt.valid_address_strobe = 1'b0;
      end
      ST_HALT, ST_WAIT: begin
        bus_nxt.addr_oe              = 1'b0;  // R8
        bus_nxt.rw_oe                = 1'b0;  // R17
        bus_nxt.data_oe              = 1'b0;
        bus_nxt.valid_address_strobe = 1'b0;
        bus_nxt.bus_avail            = 1'b1;  // R21
      end
      default: begin
        bus_nxt.bus_avail = 1'b0;
      end
    endcase
    if (pins_s.address_float_control) begin
      bus_nxt.addr_oe              = 1'b0;  // R9
      bus_nxt.rw_oe                = 1'b0;
      bus_nxt.valid_address_strobe = 1'b0;
      bus_nxt.bus_avail            = 1'b0;
    end
  end

  // every pin output leaves from this register
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      bus_r      <= '0;
      bus_r.addr <= `BC_RST_ADDR;
      bus_r.rw   <= 1'b1;
    end else begin
      bus_r <= bus_nxt;
    end
  end

  assign bus       = bus_r;
  assign cycle_ack = ack_r;
  assign rd_data   = rd_data_r;
  assign rd_valid  = rd_valid_r;
  assign pc_value  = pc_value_r;
  assign pc_load   = pc_load_r;
  assign int_start = int_start_r;
  assign int_kind  = int_kind_r;
  assign int_mask  = int_mask_r;

  // ****************************************
  // assertions
  // ****************************************
  localparam int FLT_CYC = `BC_FLOAT_CYC;
  localparam int VEC_MAX = 2 * int'(`BC_PH_CYC) + 4;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  AST_RESTART: assert property ( // R1
    res_rise && st_r == ST_RESET |=> st_r == ST_VEC_WAIT)
    else $error("restart not begun on reset edge");
  AST_RST_HIGH: assert property ( // R2
    st_r == ST_RESET |=> bus_r.addr[15:8] == 8'hff
      && !bus_r.valid_address_strobe)
    else $error("upper address not high in reset");
  AST_VEC_ORDER: assert property ( // R3
    $fell(bus_r.addr == `BC_VEC_HI_ADDR) && $past(pins_s.res_n)
      && $past(pins_s.res_n, 2) |-> bus_r.addr == `BC_VEC_LO_ADDR)
    else $error("second vector address not fetched next");
  AST_MASK_SET: assert property ( // R4
    pc_load_r |-> int_mask_r)
    else $error("mask clear at end of restart");
  AST_VEC_FIRST: assert property ( // R6
    res_rise |-> ##[1:VEC_MAX] (bus_r.addr == `BC_VEC_HI_ADDR
      && bus_r.valid_address_strobe) || !pins_s.res_n)
    else $error("first vector address not presented");
  AST_VAS_VALID: assert property ( // R7
    bus_r.valid_address_strobe |-> bus_r.addr_oe)
    else $error("strobe high with address floated");
  AST_FLOAT: assert property ( // R9
    $rose(pins.address_float_control) ##1 pins.address_float_control[*3]
      |-> ##[0:FLT_CYC] (!bus_r.addr_oe && !bus_r.rw_oe
      && !bus_r.valid_address_strobe && !bus_r.bus_avail))
    else $error("float control not obeyed in time");
  AST_DATA_EN: assert property ( // R13
    bus_r.data_oe |-> $past(pins_s.data_drive_enable))
    else $error("data driven without enable");
  AST_READ_NODRV: assert property ( // R14
    bus_r.data_oe |-> !bus_r.rw)
    else $error("data driven in read cycle");
  AST_IDLE_READ: assert property ( // R16
    bus_r.rw_oe && !bus_r.valid_address_strobe |-> bus_r.rw)
    else $error("read/write not resting high");
  AST_RW_OFF: assert property ( // R17
    st_r == ST_HALT || pins_s.address_float_control |=> !bus_r.rw_oe)
    else $error("read/write driven while off");
  AST_HALT_BA: assert property ( // R18
    st_r == ST_HALT && !pins_s.address_float_control
      |=> bus_r.bus_avail && !bus_r.valid_address_strobe && !bus_r.addr_oe)
    else $error("halt outputs wrong");
  AST_WAIT_BA: assert property ( // R21
    st_r == ST_WAIT && !pins_s.address_float_control
      |=> bus_r.bus_avail && !bus_r.addr_oe && !bus_r.data_oe)
    else $error("wait outputs wrong");
  AST_WAIT_EXIT: assert property ( // R22
    st_r == ST_WAIT && p1_start && nmi_pend_r && pins_s.res_n
      |=> st_r == ST_RUN && int_start_r && int_kind_r == INT_NMI)
    else $error("wait not left on nmi");
  AST_INT_END: assert property ( // R23
    int_start_r |-> $past(cyc_r.last) || $past(st_r) == ST_WAIT)
    else $error("interrupt started mid instruction");

  COV_RESTART: cover property (pc_load_r);
  COV_STEP: cover property (st_r == ST_HALT ##1 st_r == ST_RUN);
  COV_WAIT_IRQ: cover property (st_r == ST_WAIT ##1 int_start_r
    && int_kind_r == INT_IRQ);
  COV_FLOAT: cover property ($fell(bus_r.addr_oe) && st_r == ST_RUN);
endmodule

// [common/bc_cfg.svh]
`ifndef BC_CFG_SVH
`define BC_CFG_SVH
// ****************************************
// clock and phase timing
// ****************************************
`define BC_CLK_NS      10
`define BC_PHASE_NS    500
`define BC_PH_CYC      7'((`BC_PHASE_NS + `BC_CLK_NS - 1) / `BC_CLK_NS)
`define BC_CYC_MAX     7'(2 * `BC_PH_CYC - 1)
`define BC_FLOAT_NS    500
`define BC_FLOAT_CYC   (`BC_FLOAT_NS / `BC_CLK_NS)
// ****************************************
// bus widths, addresses, reset values
// ****************************************
`define BC_ADDR_W      16
`define BC_DATA_W      8
`define BC_VEC_HI_ADDR 16'hfffe
`define BC_VEC_LO_ADDR 16'hffff
`define BC_RST_ADDR    16'hff00
`define BC_PIN_RST     6'h2c
`define BC_DATA_RST    8'h00
`endif

// [common/bc_pkg.sv]
`include "bc_cfg.svh"
package bc_pkg;
  // ****************************************
  // sequencer states
  // ****************************************
  typedef enum logic [2:0] {
    ST_RESET, ST_VEC_WAIT, ST_VEC_HI, ST_VEC_LO, ST_RUN, ST_HALT, ST_WAIT
  } bc_state_t;
  // interrupt kind handed to the core
  typedef enum logic {INT_NMI, INT_IRQ} bc_int_t;
  // one bus cycle asked for by the core
  typedef struct packed {
    logic                  valid;  // cycle carries a real address
    logic                  rw;     // 1 read, 0 write
    logic                  last;   // final cycle of an instruction
    logic                  wai;    // instruction was wait-for-interrupt
    logic [`BC_ADDR_W-1:0] addr;
    logic [`BC_DATA_W-1:0] wdata;
  } bc_req_t;
  // device pin inputs, active-low ones marked _n
  typedef struct packed {
    logic halt_n;
    logic res_n;
    logic irq_n;
    logic nmi_n;
    logic address_float_control;
    logic data_drive_enable;
  } bc_pins_t;
  // device pin outputs with their enables
  typedef struct packed {
    logic [`BC_ADDR_W-1:0] addr;
    logic                  addr_oe;
    logic                  rw;
    logic                  rw_oe;
    logic [`BC_DATA_W-1:0] data;
    logic                  data_oe;
    logic                  valid_address_strobe;
    logic                  bus_avail;
  } bc_bus_t;
endpackage

// [design/bc_pin_sync.sv]
`timescale 1ns/10ps
// ****************************************
// two-stage synchroniser, one per bit
// ****************************************
module bc_pin_sync #(
  parameter int           W   = 1,
  parameter logic [W-1:0] RST = '0
) (
  // clock and reset
  input  wire logic         ref_clk,
  input  wire logic         rst_n,
  // asynchronous in, synchronised out
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  genvar i;
  generate
    for (i = 0; i < W; i++) begin : g_bit
      logic [1:0] stg_r;  // stage 0 feeds stage 1 only
      // shift the pin through both stages
      always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
          stg_r <= {2{RST[i]}};
        end else begin
          stg_r <= {stg_r[0], din[i]};
        end
      end
      assign dout[i] = stg_r[1];
    end
  endgenerate
endmodule

// [design/bc_phase_gen.sv]
`timescale 1ns/10ps
`include "bc_cfg.svh"
// ****************************************
// two-phase cycle timer
// ****************************************
module bc_phase_gen (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // stretch phase one while high
  input  wire logic hold,
  // phase markers
  output logic      p1_start,
  output logic      p2_start,
  output logic      phi2
);
  logic [6:0] cnt_r;      // position within one cycle
  logic [6:0] cnt_nxt;
  logic       p1_r;       // phase one begins
  logic       p2_r;       // phase two begins
  logic       phi2_r;     // phase two level

  // hold parks the count at the tail of phase one, so no edge is lost
  always_comb begin
    if (hold && cnt_r == `BC_PH_CYC - 7'd1) begin
      cnt_nxt = cnt_r;
    end else if (cnt_r == `BC_CYC_MAX) begin
      cnt_nxt = 7'd0;
    end else begin
      cnt_nxt = cnt_r + 7'd1;
    end
  end

  // counter and registered markers
  always_ff @(posedge ref_clk) begin
    if (!rst_n) begin
      cnt_r  <= 7'd0;
      p1_r   <= 1'b0;
      p2_r   <= 1'b0;
      phi2_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      p1_r   <= (cnt_nxt == 7'd0);
      p2_r   <= (cnt_nxt == `BC_PH_CYC) && (cnt_r != `BC_PH_CYC);
      phi2_r <= (cnt_nxt >= `BC_PH_CYC);
    end
  end

  assign p1_start = p1_r;
  assign p2_start = p2_r;
  assign phi2     = phi2_r;
endmodule

// [verif/bc_mem_model.sv]
`timescale 1ns/10ps
// ****************************************
// memory partner: answers reads only
// ****************************************
module bc_mem_model (
  // clock
  input  wire logic            ref_clk,
  // device bus pins
  input  wire bc_pkg::bc_bus_t bus,
  // data pins back to the device
  output logic [7:0]           data_in
);
  import bc_pkg::*;
  logic [7:0] junk_r = 8'h96;  // released-bus pattern
  // released lines change every cycle, so a stale byte cannot pass
  always_ff @(posedge ref_clk) begin
    junk_r <= junk_r + 8'h3b;
  end
  // selected read: byte is a fixed function of the address
  always_comb begin
    if (bus.addr_oe && bus.rw && bus.valid_address_strobe) begin
      data_in = bus.addr[7:0] + 8'h5a;
    end else begin
      data_in = junk_r;
    end
  end
endmodule

// [verif/bc_bus_ctl_tb_top.sv]
`timescale 1ns/10ps
module bc_bus_ctl_tb_top;
  import bc_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic        ref_clk = 1'b0;  // 100 MHz
  logic        rst_n   = 1'b0;  // held three cycles
  logic        mask_clear = 1'b0;
  bc_pins_t    pins;            // raw device pins
  bc_req_t     core_req;        // core request, held until ack
  bc_bus_t     bus;
  logic        cycle_ack, rd_valid, pc_load, int_start, int_mask;
  logic [7:0]  rd_data, data_in;
  logic [15:0] pc_value;
  bc_int_t     int_kind;
  int          n_errors = 0;
  int          n_tests  = 0;
  always #5 ref_clk = ~ref_clk;
  bc_bus_ctl dut (.ref_clk(ref_clk), .rst_n(rst_n), .pins(pins),
    .data_in(data_in), .bus(bus), .core_req(core_req),
    .mask_clear(mask_clear), .cycle_ack(cycle_ack), .rd_data(rd_data),
    .rd_valid(rd_valid), .pc_value(pc_value), .pc_load(pc_load),
    .int_start(int_start), .int_kind(int_kind), .int_mask(int_mask));
  bc_mem_model mem (.ref_clk(ref_clk), .bus(bus), .data_in(data_in));
  // ****************************************
  // shared helpers
  // ****************************************
  task automatic wrap_up();
    if (n_errors == 0 && n_tests > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  // compare, four-state exact
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // selectable event to wait on
  function automatic logic pick(input int sel);
    case (sel)
      0: pick = cycle_ack;
      1: pick = rd_valid;
      2: pick = pc_load;
      3: pick = int_start;
      4: pick = bus.bus_avail;
      5: pick = bus.valid_address_strobe;
      default: pick = bus.valid_address_strobe && bus.addr == 16'hffff;
    endcase
  endfunction
  // bounded wait; a phase is 50 clocks, so 400 covers any slot
  task automatic wait_for(input int sel);
    for (int i = 0; i < 400; i++) begin
      @(posedge ref_clk);
      if (pick(sel) === 1'b1) return;
    end
    n_errors++;
    wrap_up();
  endtask
  // one core bus cycle, held until taken
  task automatic do_cyc(input logic rw, input logic last, input logic wai,
                        input logic [15:0] a, input logic [7:0] wd);
    core_req <= '{valid: 1'b1, rw: rw, last: last, wai: wai,
                  addr: a, wdata: wd};
    wait_for(0);
    core_req.valid <= 1'b0;
    // bus pins follow the ack by one clock
    @(posedge ref_clk);
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    chk(bus.addr_oe, 1'b0);
    chk(bus.valid_address_strobe, 1'b0);
    chk(int_mask, 1'b1);
    rst_n <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk(bus.addr[15:8], 8'hff);
    chk(bus.addr_oe, 1'b1);
    chk(bus.bus_avail, 1'b0);
    repeat (800) @(posedge ref_clk);
    pins.res_n <= 1'b1;
  endtask
  task automatic t_restart();
    wait_for(5);
    chk(bus.addr, 16'hfffe);
    chk(bus.rw, 1'b1);
    wait_for(6);
    chk(bus.addr, 16'hffff);
    wait_for(2);
    chk(pc_value, 16'h5859);
    chk(int_mask, 1'b1);
  endtask
  // read with data enable high: drivers stay off
  task automatic t_read();
    pins.data_drive_enable <= 1'b1;
    do_cyc(1'b1, 1'b1, 1'b0, 16'h1234, 8'h00);
    chk(bus.addr, 16'h1234);
    chk(bus.valid_address_strobe, 1'b1);
    chk({bus.rw, bus.rw_oe}, 2'b11);
    chk(bus.data_oe, 1'b0);
    wait_for(1);
    chk(rd_data, 8'h8e);
  endtask
  // write, then float the address side mid-cycle
  task automatic t_write_float();
    do_cyc(1'b0, 1'b1, 1'b0, 16'h4321, 8'ha5);
    chk(bus.rw, 1'b0);
    repeat (5) @(posedge ref_clk);
    chk({bus.data_oe, bus.data}, 9'h1a5);
    pins.address_float_control <= 1'b1;
    repeat (5) @(posedge ref_clk);
    chk({bus.addr_oe, bus.rw_oe}, 2'b00);
    chk(bus.valid_address_strobe, 1'b0);
    chk(bus.bus_avail, 1'b0);
    chk(bus.data_oe, 1'b1);
    pins.address_float_control <= 1'b0;
    pins.data_drive_enable <= 1'b0;
    repeat (5) @(posedge ref_clk);
    chk(bus.data_oe, 1'b0);
  endtask
  // halt, then release together with the next request
  task automatic t_halt();
    pins.halt_n <= 1'b0;
    wait_for(4);
    chk(bus.valid_address_strobe, 1'b0);
    chk({bus.addr_oe, bus.rw_oe, bus.data_oe}, 3'b000);
    pins.halt_n <= 1'b1;
    do_cyc(1'b1, 1'b1, 1'b0, 16'h2000, 8'h00);
    chk(bus.addr, 16'h2000);
  endtask
  // wait-for-interrupt left by irq (mask clear) or nmi (mask set)
  task automatic t_wait_int(input logic use_nmi);
    if (!use_nmi) begin
      mask_clear <= 1'b1;
      @(posedge ref_clk);
      mask_clear <= 1'b0;
      repeat (3) @(posedge ref_clk);
      chk(int_mask, 1'b0);
    end
    do_cyc(1'b1, 1'b1, 1'b1, 16'h0100, 8'h00);
    wait_for(4);
    chk({bus.valid_address_strobe, bus.addr_oe}, 2'b00);
    if (use_nmi) pins.nmi_n <= 1'b0;
    else pins.irq_n <= 1'b0;
    wait_for(3);
    chk(int_kind, use_nmi ? INT_NMI : INT_IRQ);
    chk(int_mask, 1'b1);
    pins.irq_n <= 1'b1;
    pins.nmi_n <= 1'b1;
  endtask
  // device reset again mid-run: restart repeats from the vectors
  task automatic t_rerun();
    pins.res_n <= 1'b0;
    repeat (800) @(posedge ref_clk);
    chk(bus.addr[15:8], 8'hff);
    chk(bus.bus_avail, 1'b0);
    pins.res_n <= 1'b1;
    t_restart();
  endtask
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    pins = '{halt_n: 1'b1, res_n: 1'b0, irq_n: 1'b1, nmi_n: 1'b1,
             address_float_control: 1'b0, data_drive_enable: 1'b0};
    core_req = '0;
    repeat (3) @(posedge ref_clk);
    t_reset();
    t_restart();
    t_read();
    t_write_float();
    t_halt();
    t_wait_int(1'b0);
    t_wait_int(1'b1);
    t_rerun();
    wrap_up();
  end
endmodule
